// File: line_port_mode_path_control.sv
// direction, routing, power and host equalizer control for a bidirectional serial video port
// How it works
// - direction low: line port input, host output on, line driver off.
// - direction high: host input used, line driver on, line equalizer off.
// - direction may change any time; each change pulses a clock recovery reset.
// - receive direction enables host output whatever host output select says.
// - secondary output on when its select is low, off when high.
// - transmit direction loops host input to host output when select is low.
// - carrier detector watches line port in receive, host input in transmit.
// - no carrier enters power save; carrier back returns to normal.
// - enable low forces power-down and ignores the input.
// - power save keeps carrier detector and management alive; power-down only management.
// - carrier status readable; register routes signal_present_n onto lock pin.
// - register enables half-amplitude splitter input handling in receive direction.
// - host equalizer off in receive, line equalizer off in transmit.
// - receive direction runs line equalizer self-adapting boost and offset loops.
// - host equalizer has fixed mode and a search over sixteen table boosts.
// - strap H fixed 00, F search at 3G else 00, R 80, L 90.
// - register override replaces strap adapt mode and boost.
// - each strap resolves to one of four levels by three thresholds.
`timescale 1ns/1ps
module line_port_mode_path_control
    import line_port_pkg::*;
#(
    parameter int SEARCH_ENTRIES = 16
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] direction_select_cmp,
    input wire logic [2:0] host_out_select_cmp,
    input wire logic [2:0] secondary_out_select_cmp,
    input wire logic [2:0] host_eq_strap_cmp,
    input wire logic enable,
    input wire logic line_carrier,
    input wire logic host_carrier,
    input wire logic rate_is_3g,
    input wire logic [7:0] eye_quality,
    input wire logic cdr_lock_n,
    output logic line_eq_en,
    output logic line_eq_adapt,
    output logic line_driver_en,
    output logic host_eq_en,
    output logic host_eq_searching,
    output logic [7:0] host_eq_boost,
    output logic host_output_en,
    output logic host_loopback,
    output logic secondary_out_en,
    output logic splitter_mode,
    output logic carrier_detect_en,
    output logic power_save,
    output logic power_down,
    output logic cdr_reset,
    output logic lock_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int IDX_W = $clog2(SEARCH_ENTRIES);

    ////////////////////////////////////////////////////////////////////////////
    // strap resolution
    logic [2:0] cmp_w [4];
    logic [1:0] lvl_w [4];
    assign cmp_w[0] = direction_select_cmp;
    assign cmp_w[1] = host_out_select_cmp;
    assign cmp_w[2] = secondary_out_select_cmp;
    assign cmp_w[3] = host_eq_strap_cmp;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_strap
            strap_level_sync u_sync (
                .clock(clock),
                .rst(rst),
                .above_cmp(cmp_w[g]),
                .level(lvl_w[g])
            );
        end
    endgenerate

    // two-level use of a four-level strap: H or F read as high
    function automatic logic is_high(input logic [1:0] lvl);
        return lvl[1];
    endfunction

    logic dir_hi, out_sel_hi, sec_sel_hi;
    assign dir_hi = is_high(lvl_w[0]);
    assign out_sel_hi = is_high(lvl_w[1]);
    assign sec_sel_hi = is_high(lvl_w[2]);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] ctrl_r;
    logic [7:0] search_tbl_r [SEARCH_ENTRIES];
    logic [1:0] warm_r;
    logic straps_ok;
    logic dir_prev_r;
    logic [6:0] cdr_cnt_r;
    search_state_t srch_r;
    logic [IDX_W-1:0] srch_idx_r, best_idx_r;
    logic [7:0] best_q_r, srch_boost_r;
    logic [8:0] settle_r;

    assign straps_ok = (warm_r == 2'(STRAP_WARMUP_CYCLES));

    ////////////////////////////////////////////////////////////////////////////
    // mode decisions
    logic carrier_sel, run, ovr, want_search;
    logic [7:0] fixed_boost;
    assign carrier_sel = dir_hi ? host_carrier : line_carrier;
    assign run = straps_ok && enable && carrier_sel;
    assign ovr = ctrl_r[CTRL_EQ_OVERRIDE_BIT];

    always_comb begin
        want_search = 1'b0;
        fixed_boost = BOOST_STRAP_H;
        if (ovr) begin
            want_search = ctrl_r[CTRL_OVR_SEARCH_BIT];
            fixed_boost = ctrl_r[CTRL_OVR_BOOST_LSB +: 8];
        end else begin
            unique case (lvl_w[3])
                LVL_H: fixed_boost = BOOST_STRAP_H;
                LVL_F: begin
                    want_search = rate_is_3g;
                    fixed_boost = BOOST_STRAP_F;
                end
                LVL_R: fixed_boost = BOOST_STRAP_R;
                LVL_L: fixed_boost = BOOST_STRAP_L;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // warm-up and direction change tracking
    logic dir_change;
    assign dir_change = straps_ok && (dir_hi != dir_prev_r);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            warm_r <= 2'h0;
            dir_prev_r <= 1'b0;
        end else begin
            if (!straps_ok) begin
                warm_r <= warm_r + 2'h1;
            end
            dir_prev_r <= dir_hi; // strap level at release taken as start direction
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cdr_cnt_r <= 7'h0;
            cdr_reset <= 1'b0;
        end else if (dir_change) begin
            cdr_cnt_r <= 7'(CDR_RESET_CYCLES - 1);
            cdr_reset <= 1'b1;
        end else if (cdr_cnt_r != 7'h0) begin
            cdr_cnt_r <= cdr_cnt_r - 7'h1;
        end else begin
            cdr_reset <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // routing and power outputs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_eq_en <= 1'b0;
            line_eq_adapt <= 1'b0;
            line_driver_en <= 1'b0;
            host_eq_en <= 1'b0;
            host_output_en <= 1'b0;
            host_loopback <= 1'b0;
            secondary_out_en <= 1'b0;
            splitter_mode <= 1'b0;
            carrier_detect_en <= 1'b0;
            power_save <= 1'b0;
            power_down <= 1'b1;
            lock_n <= 1'b1;
        end else begin
            power_down <= !enable || !straps_ok;
            carrier_detect_en <= enable && straps_ok;
            power_save <= enable && straps_ok && !carrier_sel;
            line_eq_en <= run && !dir_hi;
            line_eq_adapt <= run && !dir_hi;
            line_driver_en <= run && dir_hi;
            host_eq_en <= run && dir_hi;
            host_output_en <= run && (!dir_hi || !out_sel_hi);
            host_loopback <= run && dir_hi && !out_sel_hi;
            secondary_out_en <= run && !sec_sel_hi;
            splitter_mode <= run && !dir_hi && ctrl_r[CTRL_SPLITTER_BIT];
            lock_n <= ctrl_r[CTRL_LOCK_SHOWS_CD_BIT] ? !carrier_sel : cdr_lock_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host equalizer boost search
    logic srch_active;
    assign srch_active = run && dir_hi && want_search && !cdr_reset;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            srch_r <= SRCH_IDLE;
            srch_idx_r <= '0;
            best_idx_r <= '0;
            best_q_r <= 8'h0;
            srch_boost_r <= 8'h0;
            settle_r <= 9'h0;
        end else if (!srch_active) begin
            srch_r <= SRCH_IDLE;
        end else begin
            unique case (srch_r)
                SRCH_IDLE: begin
                    srch_idx_r <= '0;
                    best_idx_r <= '0;
                    best_q_r <= 8'h0;
                    srch_r <= SRCH_APPLY;
                end
                SRCH_APPLY: begin
                    srch_boost_r <= search_tbl_r[srch_idx_r];
                    settle_r <= 9'(SEARCH_SETTLE_CYCLES - 1);
                    srch_r <= SRCH_SETTLE;
                end
                SRCH_SETTLE: begin
                    if (settle_r != 9'h0) begin
                        settle_r <= settle_r - 9'h1;
                    end else begin
                        if (eye_quality > best_q_r) begin
                            best_q_r <= eye_quality;
                            best_idx_r <= srch_idx_r;
                        end
                        if (srch_idx_r == IDX_W'(SEARCH_ENTRIES - 1)) begin
                            srch_r <= SRCH_DONE;
                        end else begin
                            srch_idx_r <= srch_idx_r + 1'b1;
                            srch_r <= SRCH_APPLY;
                        end
                    end
                end
                SRCH_DONE: srch_boost_r <= search_tbl_r[best_idx_r];
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            host_eq_searching <= 1'b0;
            host_eq_boost <= 8'h0;
        end else begin
            host_eq_searching <= srch_active;
            // strap ignored while the host equalizer is off
            host_eq_boost <= !(run && dir_hi) ? 8'h0 : (want_search ? srch_boost_r : fixed_boost);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave
    logic aw_take, w_take, ar_take, aw_have_r, w_have_r, do_write;
    logic [11:0] aw_addr_r, wa;
    logic [31:0] w_data_r, wd;
    logic [3:0] w_strb_r, ws;
    logic aw_have_nxt, w_have_nxt, bvalid_nxt;
    logic [9:0] w_idx, r_idx;
    logic [31:0] rd_val;
    logic rd_ok;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign do_write = (aw_have_r || aw_take) && (w_have_r || w_take);
    assign wa = aw_take ? s_axi_awaddr : aw_addr_r;
    assign wd = w_take ? s_axi_wdata : w_data_r;
    assign ws = w_take ? s_axi_wstrb : w_strb_r;
    assign w_idx = wa[11:2];
    assign r_idx = s_axi_araddr[11:2];
    assign aw_have_nxt = (aw_have_r || aw_take) && !do_write;
    assign w_have_nxt = (w_have_r || w_take) && !do_write;
    assign bvalid_nxt = do_write || (s_axi_bvalid && !s_axi_bready);

    function automatic logic in_table(input logic [9:0] idx);
        return idx >= SEARCH_FIRST_IDX && idx <= SEARCH_LAST_IDX;
    endfunction

    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0;
        if (s_axi_araddr == CTRL_ADDR) begin
            rd_val[15:0] = ctrl_r;
        end else if (s_axi_araddr == STATUS_ADDR) begin
            rd_val[STAT_CARRIER_BIT] = carrier_sel;
            rd_val[STAT_DIRECTION_BIT] = dir_hi;
            rd_val[STAT_POWER_SAVE_BIT] = power_save;
            rd_val[STAT_POWER_DOWN_BIT] = power_down;
            rd_val[STAT_CDR_RESET_BIT] = cdr_reset;
            rd_val[STAT_SEARCHING_BIT] = host_eq_searching;
            rd_val[STAT_SEARCH_DONE_BIT] = (srch_r == SRCH_DONE);
            rd_val[STAT_BOOST_LSB +: 8] = host_eq_boost;
        end else if (in_table(r_idx) && s_axi_araddr[1:0] == 2'h0) begin
            rd_val[7:0] = search_tbl_r[IDX_W'(r_idx - SEARCH_FIRST_IDX)];
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 12'h0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) aw_addr_r <= s_axi_awaddr;
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            s_axi_awready <= !aw_have_nxt && !bvalid_nxt;
            s_axi_wready <= !w_have_nxt && !bvalid_nxt;
            s_axi_bvalid <= bvalid_nxt;
            if (do_write) begin
                s_axi_bresp <= (wa == CTRL_ADDR || wa == STATUS_ADDR || (in_table(w_idx) && wa[1:0] == 2'h0))
                    ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
            for (int i = 0; i < SEARCH_ENTRIES; i++) begin
                search_tbl_r[i] <= 8'(i * SEARCH_STEP);
            end
        end else if (do_write) begin
            if (wa == CTRL_ADDR) begin
                if (ws[0]) ctrl_r[7:0] <= wd[7:0];
                if (ws[1]) ctrl_r[15:8] <= wd[15:8];
            end else if (in_table(w_idx) && wa[1:0] == 2'h0 && ws[0]) begin
                search_tbl_r[IDX_W'(w_idx - SEARCH_FIRST_IDX)] <= wd[7:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    AST_RX_ROUTE: assert property (@(posedge clock) disable iff (rst)
        run && !dir_hi |=> host_output_en && line_eq_en && !line_driver_en && !host_eq_en)
        else $error("receive routing wrong");
    AST_TX_ROUTE: assert property (@(posedge clock) disable iff (rst)
        run && dir_hi |=> line_driver_en && host_eq_en && !line_eq_en)
        else $error("transmit routing wrong");
    AST_CDR_RESET: assert property (@(posedge clock) disable iff (rst)
        dir_change |=> cdr_reset [*8] ##1 (cdr_reset && cdr_cnt_r == 7'(CDR_RESET_CYCLES - 9)))
        else $error("clock recovery reset not held after direction change");
    AST_SECONDARY: assert property (@(posedge clock) disable iff (rst)
        run |=> secondary_out_en == !$past(sec_sel_hi))
        else $error("secondary output select ignored");
    AST_LOOPBACK: assert property (@(posedge clock) disable iff (rst)
        run && dir_hi && out_sel_hi |=> !host_output_en && !host_loopback)
        else $error("host output not disabled in transmit");
    AST_POWER_SAVE: assert property (@(posedge clock) disable iff (rst)
        straps_ok && enable && !carrier_sel |=> power_save && carrier_detect_en && !line_eq_en && !line_driver_en)
        else $error("power save not entered");
    AST_POWER_DOWN: assert property (@(posedge clock) disable iff (rst)
        !enable |=> power_down && !carrier_detect_en && !host_output_en && !secondary_out_en)
        else $error("power-down not forced");
    AST_LOCK_PIN: assert property (@(posedge clock) disable iff (rst)
        ctrl_r[CTRL_LOCK_SHOWS_CD_BIT] |=> lock_n == !$past(carrier_sel))
        else $error("lock pin does not show signal present");
    AST_STRAP_R: assert property (@(posedge clock) disable iff (rst)
        run && dir_hi && !ovr && lvl_w[3] == LVL_R |=> host_eq_boost == BOOST_STRAP_R && !host_eq_searching)
        else $error("strap boost decode wrong");
    AST_HOST_EQ_RX: assert property (@(posedge clock) disable iff (rst)
        !dir_hi |=> !host_eq_en && host_eq_boost == 8'h0)
        else $error("host equalizer active in receive");
endmodule

// File: line_port_pkg.sv
// constants, field positions and types shared by the serial video port control logic
package line_port_pkg;

    // clock rate and derived cycle counts
    localparam int CLK_MHZ = 40;
    localparam int CDR_RESET_NS = 1000;
    localparam int CDR_RESET_CYCLES = (CDR_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int SEARCH_SETTLE_NS = 2000;
    localparam int SEARCH_SETTLE_CYCLES = (SEARCH_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int STRAP_WARMUP_CYCLES = 3;

    // register byte addresses
    localparam logic [11:0] CTRL_ADDR = 12'h000;
    localparam logic [11:0] STATUS_ADDR = 12'h004;
    // search table index range, byte address is four times the index
    localparam logic [9:0] SEARCH_FIRST_IDX = 10'h040;
    localparam logic [9:0] SEARCH_LAST_IDX = 10'h04f;

    // control register fields
    localparam int CTRL_SPLITTER_BIT = 0;
    localparam int CTRL_LOCK_SHOWS_CD_BIT = 1;
    localparam int CTRL_EQ_OVERRIDE_BIT = 2;
    localparam int CTRL_OVR_SEARCH_BIT = 3;
    localparam int CTRL_OVR_BOOST_LSB = 8;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // status register fields
    localparam int STAT_CARRIER_BIT = 0;
    localparam int STAT_DIRECTION_BIT = 1;
    localparam int STAT_POWER_SAVE_BIT = 2;
    localparam int STAT_POWER_DOWN_BIT = 3;
    localparam int STAT_CDR_RESET_BIT = 4;
    localparam int STAT_SEARCHING_BIT = 5;
    localparam int STAT_SEARCH_DONE_BIT = 6;
    localparam int STAT_BOOST_LSB = 8;

    // search table default: entry i holds i times this step
    localparam logic [7:0] SEARCH_STEP = 8'h10;

    // resolved four-level strap codes
    localparam logic [1:0] LVL_L = 2'h0;
    localparam logic [1:0] LVL_R = 2'h1;
    localparam logic [1:0] LVL_F = 2'h2;
    localparam logic [1:0] LVL_H = 2'h3;

    // fixed boost levels chosen by the host equalizer strap
    localparam logic [7:0] BOOST_STRAP_H = 8'h00;
    localparam logic [7:0] BOOST_STRAP_F = 8'h00;
    localparam logic [7:0] BOOST_STRAP_R = 8'h80;
    localparam logic [7:0] BOOST_STRAP_L = 8'h90;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SRCH_IDLE = 2'b00,
        SRCH_APPLY = 2'b01,
        SRCH_SETTLE = 2'b11,
        SRCH_DONE = 2'b10
    } search_state_t;

endpackage

// File: strap_level_sync.sv
// four-level strap resolver: comparator thermometer to two-bit code, then two-flop synchroniser
`timescale 1ns/1ps
module strap_level_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] above_cmp,
    output logic [1:0] level
);
    logic [1:0] code;
    logic [1:0] meta_r;

    // comparators above 0.2, 0.5, 0.8 of supply give L, R, F, H
    always_comb begin
        code = {1'b0, above_cmp[0]} + {1'b0, above_cmp[1]} + {1'b0, above_cmp[2]};
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_r <= 2'h0;
            level <= 2'h0;
        end else begin
            meta_r <= code;
            level <= meta_r;
        end
    end
endmodule

// File: strap_board_model.sv
// board straps and host trace model: strap levels to comparator outputs, eye quality per boost
`timescale 1ns/1ps
module strap_board_model
    import line_port_pkg::*;
#(
    parameter logic [7:0] BEST_BOOST = 8'h70
) (
    input wire logic [7:0] lvl,
    input wire logic [7:0] boost,
    output logic [11:0] cmp,
    output logic [7:0] quality
);
    function automatic logic [2:0] thermo(input logic [1:0] l);
        return {l == LVL_H, l >= LVL_F, l >= LVL_R};
    endfunction
    ////////////////////////////////////////////////////////////////
    // straps held at a defined level from time zero, host eq strap decoded like the other three
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cmp[3*i +: 3] = thermo(lvl[2*i +: 2]);
        end
    end
    // trace quality peaks at one boost only
    assign quality = (boost == BEST_BOOST) ? 8'he0 : 8'h20;
endmodule

// File: test_line_port_mode_path_control.sv
// self-checking bench for the serial video port control block
`timescale 1ns/1ps
module test_line_port_mode_path_control;
    import line_port_pkg::*;
    logic clock = 1'b0, rst = 1'b1, enable = 1'b0, line_carrier = 1'b0, host_carrier = 1'b0;
    logic rate_is_3g = 1'b0, cdr_lock_n = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, prev, run;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, rd, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] lvl, eye_quality, host_eq_boost;
    logic [2:0] direction_select_cmp, host_out_select_cmp, secondary_out_select_cmp, host_eq_strap_cmp;
    logic line_eq_en, line_eq_adapt, line_driver_en, host_eq_en, host_eq_searching, host_output_en, host_loopback;
    logic secondary_out_en, splitter_mode, carrier_detect_en, power_save, power_down, cdr_reset, lock_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    ////////////////////////////////////////////////////////////////
    strap_board_model board (.lvl, .boost(host_eq_boost), .cmp({host_eq_strap_cmp, secondary_out_select_cmp,
        host_out_select_cmp, direction_select_cmp}), .quality(eye_quality));
    line_port_mode_path_control dut (.clock, .rst, .direction_select_cmp, .host_out_select_cmp,
        .secondary_out_select_cmp, .host_eq_strap_cmp, .enable, .line_carrier, .host_carrier, .rate_is_3g,
        .eye_quality, .cdr_lock_n, .line_eq_en, .line_eq_adapt, .line_driver_en, .host_eq_en, .host_eq_searching,
        .host_eq_boost, .host_output_en, .host_loopback, .secondary_out_en, .splitter_mode, .carrier_detect_en,
        .power_save, .power_down, .cdr_reset, .lock_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    // expected path enables from strap levels, enable, carriers and splitter bit
    function automatic logic [10:0] exp_path(input logic [7:0] l, input logic en, lc, hc, sp);
        logic tx, rn;
        tx = l[1];
        rn = en && (tx ? hc : lc);
        return {rn && !tx, rn && !tx, rn && tx, rn && tx, rn && (!tx || !l[3]), rn && tx && !l[3],
            rn && !l[5], en, en && !rn, !en, rn && !tx && sp};
    endfunction
    function automatic logic [7:0] exp_boost(input logic [7:0] l, input logic rn);
        if (!rn || !l[1])
            return 8'h00;
        return (l[7:6] == LVL_R) ? BOOST_STRAP_R : (l[7:6] == LVL_L) ? BOOST_STRAP_L : 8'h00;
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        lvl = {LVL_F, LVL_H, LVL_H, LVL_L};
        void'($urandom(32'hf563964f));
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        repeat (10) @(posedge clock);
        rd_reg(12'h104);
        chk(rd, 32'h10);
        chk(rsp, RESP_OKAY);
        wr(12'h13c, 32'h77);
        chk(rsp, RESP_OKAY);
        rd_reg(12'h13c);
        chk(rd, 32'h77);
        wr(12'h800, 32'hffffffff);
        chk(rsp, RESP_SLVERR);
        rd_reg(12'h800);
        chk(rsp, RESP_SLVERR);
        chk(rd, 32'h0);
        for (int i = 0; i < 24; i++) begin
            chk(cdr_reset, 1'b0);
            prev = lvl[1];
            lvl <= 8'($urandom);
            enable <= ($urandom % 5) != 0;
            line_carrier <= 1'($urandom);
            host_carrier <= 1'($urandom);
            cdr_lock_n <= 1'($urandom);
            repeat (6) @(posedge clock);
            run = enable && (lvl[1] ? host_carrier : line_carrier);
            chk({line_eq_en, line_eq_adapt, line_driver_en, host_eq_en, host_output_en, host_loopback,
                secondary_out_en, carrier_detect_en, power_save, power_down, splitter_mode},
                exp_path(lvl, enable, line_carrier, host_carrier, 1'b0));
            chk(host_eq_boost, exp_boost(lvl, run));
            chk(cdr_reset, lvl[1] != prev);
            chk(lock_n, cdr_lock_n);
            rd_reg(STATUS_ADDR);
            chk(rd, {16'h0, exp_boost(lvl, run), 3'h0, lvl[1] != prev, !enable, enable && !run, lvl[1],
                lvl[1] ? host_carrier : line_carrier});
            repeat (44) @(posedge clock);
        end
        lvl <= {LVL_F, LVL_H, LVL_H, LVL_H};
        enable <= 1'b1;
        host_carrier <= 1'b1;
        rate_is_3g <= 1'b1;
        repeat (60) @(posedge clock);
        chk(host_eq_searching, 1'b1);
        repeat (16 * (1 + SEARCH_SETTLE_CYCLES) + 40) @(posedge clock);
        chk(host_eq_boost, 8'h70);
        rd_reg(STATUS_ADDR);
        chk(rd[6], 1'b1);
        rate_is_3g <= 1'b0;
        lvl <= {LVL_H, LVL_H, LVL_H, LVL_H};
        wr(CTRL_ADDR, 32'h5a04);
        chk(rsp, RESP_OKAY);
        repeat (3) @(posedge clock);
        chk({host_eq_searching, host_eq_boost}, 9'h05a);
        rd_reg(CTRL_ADDR);
        chk(rd, 32'h5a04);
        cdr_lock_n <= 1'b1;
        wr(CTRL_ADDR, 32'h000e);
        repeat (3) @(posedge clock);
        chk({host_eq_searching, lock_n}, 2'b10);
        host_carrier <= 1'b0;
        cdr_lock_n <= 1'b0;
        repeat (3) @(posedge clock);
        chk(lock_n, 1'b1);
        wr(CTRL_ADDR, 32'h0001);
        lvl <= {LVL_F, LVL_L, LVL_L, LVL_L};
        line_carrier <= 1'b1;
        repeat (6) @(posedge clock);
        chk({line_eq_en, line_eq_adapt, line_driver_en, host_eq_en, host_output_en, host_loopback,
            secondary_out_en, carrier_detect_en, power_save, power_down, splitter_mode},
            exp_path(lvl, 1'b1, 1'b1, 1'b0, 1'b1));
        give_verdict();
    end
endmodule
